// ---- logic/sdpm_pkg.sv ----
// Shared constants and carrier types for the SD host power/config registers
`default_nettype none
package sdpm_pkg;

  // ==========================================================================
  // Configuration offsets (byte addresses)
  localparam logic [7:0] PMCSR_OFS = 8'h84;  // Power control/status, 16 bit
  localparam logic [7:0] BSE_OFS   = 8'h86;  // Bridge extension, fixed
  localparam logic [7:0] PDATA_OFS = 8'h87;  // Power data, fixed
  localparam logic [7:0] GCTL_OFS  = 8'h88;  // General control, 8 bit

  // ==========================================================================
  // Power control/status field positions
  localparam int WAKE_STAT_BIT = 15;  // Sticky wake status
  localparam int WAKE_EN_BIT   = 8;   // Wake signalling enable
  localparam int PSTATE_LSB    = 0;   // Two-bit power state

  // ==========================================================================
  // General control field positions
  localparam int REV_SEL_BIT  = 7;  // Revision select
  localparam int INT_SEL_LSB  = 5;  // Two-bit interrupt select
  localparam int COLD_BIT     = 4;  // Cold-state wake support
  localparam int CORE_RST_BIT = 3;  // Core reset scope
  localparam int HIGH_SPEED_BIT = 1;  // High-speed enable
  localparam int DMA_EN_BIT   = 0;  // DMA enable

  // ==========================================================================
  // Reset values and fixed read values
  localparam logic [15:0] PMCSR_RST = 16'h0000;
  localparam logic [7:0]  GCTL_RST  = 8'h00;
  localparam logic [7:0]  BSE_VAL   = 8'h00;
  localparam logic [7:0]  PDATA_VAL = 8'h00;

  // ==========================================================================
  // Reported codes
  localparam logic [2:0] REV_OLD    = 3'h2;   // Revision 1.1 report
  localparam logic [2:0] REV_NEW    = 3'h3;   // Revision 1.2 report
  localparam logic [2:0] AUX_SELF   = 3'h0;   // Self powered
  localparam logic [2:0] AUX_55MA   = 3'h1;   // Aux current draw
  localparam logic [7:0] IFCODE_DMA  = 8'h01;  // Interface code with DMA
  localparam logic [7:0] IFCODE_NONE = 8'h00;  // Interface code without DMA
  localparam logic [7:0] PIN_CODE_A  = 8'h01;  // Pin code of the first line

  // Power state encoding
  typedef enum logic [1:0] {
    SDPM_D0    = 2'h0,
    SDPM_D1    = 2'h1,
    SDPM_D2    = 2'h2,
    SDPM_D3HOT = 2'h3
  } sdpm_pstate_t;

  // Configuration cycle request
  typedef struct packed {
    logic        rd;     // Read strobe, one cycle
    logic        wr;     // Write strobe, one cycle
    logic [7:2]  addr;   // Dword address
    logic [3:0]  be;     // Byte enables
    logic [31:0] wdata;  // Write data
  } sdpm_cfg_req_t;

  // Values reflected into other registers of the function
  typedef struct packed {
    logic       cold_wake_capable;
    logic [2:0] aux_current;
    logic [2:0] pm_revision_field;
    logic       high_speed_cap;
    logic       dma_cap;
    logic [7:0] prog_interface_code;
    logic [7:0] intr_pin_register;
  } sdpm_caps_t;

endpackage : sdpm_pkg
`default_nettype wire

// ---- logic/sdpm_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sdpm_sync #(
  parameter int W = 1  // Number of bits
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Pin side and clean side
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ==========================================================================
  // Stages
  logic [W-1:0] s1;  // Metastable stage, read only by s2
  logic [W-1:0] s2;  // Second stage
  logic [W-1:0] s3;  // Third stage

  // Shift chain
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Output only moves once two settled stages agree, per bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end

endmodule : sdpm_sync
`default_nettype wire

// ---- logic/sdpm_intr_route.sv ----
// Interrupt line steering from select field or override pins
`timescale 1ns/1ps
`default_nettype none
module sdpm_intr_route (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Selection
  input  wire logic [1:0] int_sel,
  input  wire logic [3:0] override,
  // Request in, lines out
  input  wire logic       core_irq,
  output logic      [3:0] intr_req,
  output logic      [1:0] line_idx
);

  // ==========================================================================
  // Pick a line: lowest asserted override pin beats the select field
  always_comb begin
    line_idx = int_sel;
    if (override != 4'h0) begin  // Select field ignored [RULE_13]
      line_idx = 2'h3;
      for (int i = 2; i >= 0; i--) begin
        if (override[i]) begin
          line_idx = 2'(i);
        end
      end
    end
  end

  // Registered line drive, one-hot onto the chosen line [RULE_12]
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      intr_req <= 4'h0;
    end else begin
      intr_req <= core_irq ? (4'h1 << line_idx) : 4'h0;
    end
  end

endmodule : sdpm_intr_route
`default_nettype wire

// ---- logic/sdpm_config.sv ----
// Power-management and general control registers of the SD host function
// Contract
// (RULE_01) Status/control survives the D3hot exit reset
// (RULE_02) Wake status resets zero, hardware sets, software clears
// (RULE_03) Data scale and select read zero
// (RULE_04) Bit 8 enables wake signalling
// (RULE_05) Status/control bits 7..2 read zero
// (RULE_06) Power state codes D0, D1, D2, D3hot
// (RULE_07) Power state reads current, write moves it
// (RULE_08) Wake and power fields: global reset only
// (RULE_09) Bridge extension byte reads 00h, read-only
// (RULE_10) Power data byte reads 00h, read-only
// (RULE_11) Control bit 7 picks revision 010b/011b
// (RULE_12) Interrupt select programs pin and line
// (RULE_13) Override pins make select field ignored
// (RULE_14) Control bit 4 drives cold wake capability
// (RULE_15) Bit 3 sets core reset scope
// (RULE_16) Control bit 2 reads zero
// (RULE_17) Control bit 1 mirrors high-speed capability
// (RULE_18) Control bit 0 drives interface code, DMA
// (RULE_19) Sticky control fields: global reset only
// (RULE_20) Aux current follows cold wake capability
// (RULE_21) Writable fields reset to zero
`timescale 1ns/1ps
`default_nettype none
module sdpm_config (
  // Clock and global reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Pins from outside the clock domain
  input  wire logic                  bus_reset_n,
  input  wire logic [3:0]            intr_override_pins,
  // Core-side events
  input  wire logic                  wake_event,
  input  wire logic                  core_irq,
  // Configuration cycles
  input  wire sdpm_pkg::sdpm_cfg_req_t cfg_req,
  output logic                       cfg_ack,
  output logic      [31:0]           cfg_rdata,
  // Reflected values and controls
  output sdpm_pkg::sdpm_caps_t       caps,
  output logic      [1:0]            power_state_field,
  output logic                       wake_request,
  output logic                       d3_exit_reset,
  output logic                       func_reset,
  output logic                       sd_core_reset,
  output logic      [3:0]            intr_req
);

  // ==========================================================================
  // Register state
  logic       wake_status;             // Sticky wake status
  logic       wake_signal_enable;      // Wake enable
  logic       pm_revision_select;      // Revision select
  logic [1:0] int_sel;                 // Interrupt select
  logic       cold_wake_support_ctrl;  // Cold-state wake support
  logic       core_rst_ctrl;           // Core reset scope
  logic       high_speed_enable;       // High-speed enable
  logic       dma_en;                  // DMA enable
  logic       bus_reset;               // Clean bus reset, active high
  logic       bus_reset_q;             // Synchronised bus reset, active high
  logic [3:0] override_q;              // Synchronised override pins
  logic [1:0] line_idx;                // Interrupt line in use
  logic       soft_reset;              // Bus or D3hot exit reset
  logic       in_soft_reset;           // Soft reset already seen last cycle
  logic       scope_held;              // Scope bit as a soft reset began
  logic       core_scope;              // Scope bit in force this cycle

  // Decode helpers
  logic       pm_hit;   // Dword holding status/control
  logic       gc_hit;   // Dword holding general control
  logic       pm_wr0;   // Write to status/control low byte
  logic       pm_wr1;   // Write to status/control high byte
  logic       gc_wr;    // Write to general control
  logic [7:0] gc_byte;  // General control as read
  logic [15:0] pm_word; // Status/control as read

  // ==========================================================================
  // Pin synchronisers
  sdpm_sync #(.W(1)) u_sync_busrst (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (~bus_reset_n),
    .q       (bus_reset_q)
  );

  sdpm_sync #(.W(4)) u_sync_ovr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (intr_override_pins),
    .q       (override_q)
  );

  // The pin is inverted ahead of the synchroniser so that its reset value
  // of zero means released; otherwise every global reset would be
  // followed by a false bus reset while the stages refill.
  assign bus_reset  = bus_reset_q;
  assign soft_reset = bus_reset | d3_exit_reset;

  // ==========================================================================
  // Address decode
  assign pm_hit = (cfg_req.addr == sdpm_pkg::PMCSR_OFS[7:2]);
  assign gc_hit = (cfg_req.addr == sdpm_pkg::GCTL_OFS[7:2]);
  assign pm_wr0 = cfg_req.wr & pm_hit & cfg_req.be[0];
  assign pm_wr1 = cfg_req.wr & pm_hit & cfg_req.be[1];
  assign gc_wr  = cfg_req.wr & gc_hit & cfg_req.be[0];

  // ==========================================================================
  // Power state: written value becomes the present state
  always_ff @(posedge ref_clk) begin
    if (rst) begin  // Global reset only [RULE_08]
      power_state_field <= sdpm_pkg::PMCSR_RST[1:0];  // [RULE_21]
    end else if (pm_wr0) begin  // Any of the four codes is taken [RULE_06]
      power_state_field <= cfg_req.wdata[sdpm_pkg::PSTATE_LSB +: 2];  // [RULE_07]
    end
  end

  // Internal reset pulse when software moves D3hot back to D0
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      d3_exit_reset <= 1'b0;
    end else begin
      d3_exit_reset <= pm_wr0
        && (power_state_field == sdpm_pkg::SDPM_D3HOT)
        && (cfg_req.wdata[1:0] == sdpm_pkg::SDPM_D0);
    end
  end

  // ==========================================================================
  // Wake enable; untouched by the D3hot exit and bus resets [RULE_01]
  always_ff @(posedge ref_clk) begin
    if (rst) begin  // [RULE_08]
      wake_signal_enable <= sdpm_pkg::PMCSR_RST[sdpm_pkg::WAKE_EN_BIT];
    end else if (pm_wr1) begin
      wake_signal_enable <= cfg_req.wdata[sdpm_pkg::WAKE_EN_BIT];
    end
  end

  // Wake status: write one clears, but a same-cycle event wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin  // [RULE_08]
      wake_status <= 1'b0;  // [RULE_02]
    end else if (wake_event) begin
      wake_status <= 1'b1;  // [RULE_02]
    end else if (pm_wr1 && cfg_req.wdata[sdpm_pkg::WAKE_STAT_BIT]) begin
      wake_status <= 1'b0;  // [RULE_02]
    end
  end

  // Wake signalling only while enabled
  assign wake_request = wake_status & wake_signal_enable;  // [RULE_04]

  // ==========================================================================
  // Sticky general control fields, cleared by global reset alone
  always_ff @(posedge ref_clk) begin
    if (rst) begin  // [RULE_19]
      pm_revision_select     <= sdpm_pkg::GCTL_RST[sdpm_pkg::REV_SEL_BIT];
      int_sel                <= sdpm_pkg::GCTL_RST[sdpm_pkg::INT_SEL_LSB +: 2];
      cold_wake_support_ctrl <= sdpm_pkg::GCTL_RST[sdpm_pkg::COLD_BIT];
      dma_en                 <= sdpm_pkg::GCTL_RST[sdpm_pkg::DMA_EN_BIT];  // [RULE_21]
    end else if (gc_wr) begin
      pm_revision_select     <= cfg_req.wdata[sdpm_pkg::REV_SEL_BIT];
      int_sel                <= cfg_req.wdata[sdpm_pkg::INT_SEL_LSB +: 2];
      cold_wake_support_ctrl <= cfg_req.wdata[sdpm_pkg::COLD_BIT];
      dma_en                 <= cfg_req.wdata[sdpm_pkg::DMA_EN_BIT];
    end
  end

  // Non-sticky control fields also fall to bus and D3hot exit resets;
  // the reset wins over a write landing in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst || soft_reset) begin  // [RULE_21]
      core_rst_ctrl     <= sdpm_pkg::GCTL_RST[sdpm_pkg::CORE_RST_BIT];
      high_speed_enable <= sdpm_pkg::GCTL_RST[sdpm_pkg::HIGH_SPEED_BIT];
    end else if (gc_wr) begin
      core_rst_ctrl     <= cfg_req.wdata[sdpm_pkg::CORE_RST_BIT];
      high_speed_enable <= cfg_req.wdata[sdpm_pkg::HIGH_SPEED_BIT];
    end
  end

  // ==========================================================================
  // Scope capture: the soft reset clears the scope bit itself, so the
  // value in force when the reset began is held for its whole length;
  // without this a long bus reset reaches the core after one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_soft_reset <= 1'b0;
      scope_held    <= 1'b0;
    end else begin
      in_soft_reset <= soft_reset;
      if (!in_soft_reset) begin  // Track freely outside soft resets
        scope_held <= core_rst_ctrl;
      end
    end
  end

  // First cycle uses the live bit, later cycles the captured one
  assign core_scope = in_soft_reset ? scope_held : core_rst_ctrl;  // [RULE_15]

  // ==========================================================================
  // Reset outputs: the PCI portion always sees bus reset, the core only
  // when the scope bit leaves it exposed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      func_reset    <= 1'b1;
      sd_core_reset <= 1'b1;
    end else begin
      func_reset    <= soft_reset;
      sd_core_reset <= soft_reset & ~core_scope;  // [RULE_15]
    end
  end

  // ==========================================================================
  // Interrupt steering
  sdpm_intr_route u_intr (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .int_sel  (int_sel),
    .override (override_q),
    .core_irq (core_irq),
    .intr_req (intr_req),
    .line_idx (line_idx)
  );

  // ==========================================================================
  // Values reflected into capability, class and socket registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      caps <= '0;
    end else begin
      caps.cold_wake_capable   <= cold_wake_support_ctrl;  // [RULE_14]
      caps.aux_current         <= cold_wake_support_ctrl ?
                                  sdpm_pkg::AUX_55MA : sdpm_pkg::AUX_SELF;  // [RULE_20]
      caps.pm_revision_field   <= pm_revision_select ?
                                  sdpm_pkg::REV_NEW : sdpm_pkg::REV_OLD;  // [RULE_11]
      caps.high_speed_cap      <= high_speed_enable;  // [RULE_17]
      caps.dma_cap             <= dma_en;  // [RULE_18]
      caps.prog_interface_code <= dma_en ?
                                  sdpm_pkg::IFCODE_DMA : sdpm_pkg::IFCODE_NONE;  // [RULE_18]
      caps.intr_pin_register   <= sdpm_pkg::PIN_CODE_A + {6'h00, line_idx};  // [RULE_12]
    end
  end

  // ==========================================================================
  // Read view; reserved and unimplemented fields are constant zero
  always_comb begin
    pm_word = 16'h0000;  // Scale, select and bits 7..2 stay zero [RULE_03] [RULE_05]
    pm_word[sdpm_pkg::WAKE_STAT_BIT]      = wake_status;
    pm_word[sdpm_pkg::WAKE_EN_BIT]        = wake_signal_enable;
    pm_word[sdpm_pkg::PSTATE_LSB +: 2]    = power_state_field;
    gc_byte = 8'h00;  // Bit 2 stays zero [RULE_16]
    gc_byte[sdpm_pkg::REV_SEL_BIT]        = pm_revision_select;
    gc_byte[sdpm_pkg::INT_SEL_LSB +: 2]   = int_sel;
    gc_byte[sdpm_pkg::COLD_BIT]           = cold_wake_support_ctrl;
    gc_byte[sdpm_pkg::CORE_RST_BIT]       = core_rst_ctrl;
    gc_byte[sdpm_pkg::HIGH_SPEED_BIT]     = high_speed_enable;
    gc_byte[sdpm_pkg::DMA_EN_BIT]         = dma_en;
  end

  // Read data registered, acknowledge one cycle after each strobe;
  // fixed bytes ignore writes, unmapped dwords read zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack <= cfg_req.rd | cfg_req.wr;
      if (cfg_req.rd) begin
        if (pm_hit) begin
          cfg_rdata <= {sdpm_pkg::PDATA_VAL, sdpm_pkg::BSE_VAL, pm_word};  // [RULE_09] [RULE_10]
        end else if (gc_hit) begin
          cfg_rdata <= {24'h00_0000, gc_byte};
        end else begin
          cfg_rdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_wake_set_wins: assert property (wake_event |=> wake_status)  // [RULE_02]
    else $error("wake status not set after event");

  a_wake_gated: assert property (!wake_signal_enable |-> !wake_request)  // [RULE_04]
    else $error("wake request while disabled");

  a_wake_raise: assert property (wake_event && wake_signal_enable && !pm_wr1
      |=> wake_request)  // [RULE_04]
    else $error("enabled wake event gave no request");

  a_pm_fixed_zero: assert property (cfg_req.rd && pm_hit
      |=> cfg_rdata[31:16] == 16'h0000 && cfg_rdata[14:9] == 6'h00)  // [RULE_03]
    else $error("fixed power fields not zero");

  a_pm_rsvd_zero: assert property (cfg_req.rd && pm_hit
      |=> cfg_rdata[7:2] == 6'h00)  // [RULE_05]
    else $error("reserved status bits not zero");

  a_pstate_write: assert property (pm_wr0
      |=> power_state_field == $past(cfg_req.wdata[1:0]))  // [RULE_07]
    else $error("power state did not take write");

  a_d3_exit_keep: assert property (d3_exit_reset && !cfg_req.wr
      |=> $stable(wake_signal_enable) && $stable(power_state_field))  // [RULE_01]
    else $error("status changed by D3hot exit reset");

  a_rev_report: assert property (gc_wr
      |=> ##1 caps.pm_revision_field == ($past(cfg_req.wdata[7], 2) ? 3'h3 : 3'h2))  // [RULE_11]
    else $error("revision report wrong");

  a_sticky_keep: assert property (bus_reset && !gc_wr
      |=> $stable(dma_en) && $stable(int_sel) && $stable(pm_revision_select))  // [RULE_19]
    else $error("sticky control lost on bus reset");

  a_core_scope: assert property ($rose(soft_reset)
      |=> sd_core_reset == !$past(core_rst_ctrl))  // [RULE_15]
    else $error("core reset scope wrong");

  a_core_steady: assert property (soft_reset && $past(soft_reset)
      |=> $stable(sd_core_reset))  // [RULE_15]
    else $error("core reset changed inside one soft reset");

  a_dma_report: assert property (gc_wr
      |=> ##1 caps.prog_interface_code == ($past(cfg_req.wdata[sdpm_pkg::DMA_EN_BIT], 2) ?
          sdpm_pkg::IFCODE_DMA : sdpm_pkg::IFCODE_NONE))  // [RULE_18]
    else $error("interface code disagrees with DMA cap");

  a_aux_follow: assert property (caps.aux_current == {2'b00, caps.cold_wake_capable})  // [RULE_20]
    else $error("aux current disagrees with cold wake");

endmodule : sdpm_config
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the SD host power/config register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================================
  // Stimulus and observed signals
  logic                    ref_clk;             // 200 MHz clock
  logic                    rst;                 // Global reset
  logic                    bus_reset_n;         // Bus reset pin
  logic [3:0]              intr_override_pins;  // Override terminals
  logic                    wake_event;          // Core wake event
  logic                    core_irq;            // Core interrupt
  sdpm_pkg::sdpm_cfg_req_t cfg_req;             // Configuration request
  logic                    cfg_ack;             // Cycle answer
  logic [31:0]             cfg_rdata;           // Read data
  sdpm_pkg::sdpm_caps_t    caps;                // Reflected values
  logic [1:0]              power_state_field;   // Current power state
  logic                    wake_request;        // Gated wake
  logic                    d3_exit_reset;       // D3hot exit pulse
  logic                    func_reset;          // PCI portion reset
  logic                    sd_core_reset;       // Core reset
  logic [3:0]              intr_req;            // Interrupt lines
  logic [31:0]             rd;                  // Last read value
  int                      fails;               // Mismatch count
  int                      comparisons;         // Comparison count

  sdpm_config DUT (
    .ref_clk(ref_clk), .rst(rst), .bus_reset_n(bus_reset_n),
    .intr_override_pins(intr_override_pins), .wake_event(wake_event),
    .core_irq(core_irq), .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .caps(caps), .power_state_field(power_state_field), .wake_request(wake_request),
    .d3_exit_reset(d3_exit_reset), .func_reset(func_reset),
    .sd_core_reset(sd_core_reset), .intr_req(intr_req)
  );

  // ==========================================================================
  // Clock: 5 ns period
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  // ==========================================================================
  // Helpers
  // Compare one value, report at once
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk

  // One configuration cycle; answer fixed 1 ns after the taking edge
  task automatic cfg_cycle(input logic is_wr, input logic [7:0] a, input logic [3:0] be,
                           input logic [31:0] wd);
    @(posedge ref_clk);
    cfg_req.rd    <= ~is_wr;
    cfg_req.wr    <= is_wr;
    cfg_req.addr  <= a[7:2];
    cfg_req.be    <= be;
    cfg_req.wdata <= wd;
    @(posedge ref_clk);
    cfg_req.rd <= 1'b0;
    cfg_req.wr <= 1'b0;
    #1;
    chk("cfg_ack", 32'h1, {31'h0, cfg_ack});
    rd = cfg_rdata;
  endtask : cfg_cycle

  // Read and compare a dword
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    cfg_cycle(1'b0, a, 4'hF, 32'h0);
    chk("cfg_rdata", exp, rd);
  endtask : rd_chk

  // Wait a number of cycles, then settle
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  // Hold the bus reset pin low long enough to pass the synchroniser
  task automatic pulse_bus_reset(input logic exp_core);
    @(posedge ref_clk);
    bus_reset_n <= 1'b0;
    idle(10);
    chk("func_reset", 32'h1, {31'h0, func_reset});
    chk("sd_core_reset", {31'h0, exp_core}, {31'h0, sd_core_reset});
    @(posedge ref_clk);
    bus_reset_n <= 1'b1;
    idle(10);
  endtask : pulse_bus_reset

  // Verdict in one place
  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    bus_reset_n = 1'b1;  // Pin high from time zero so resets drop after release
    intr_override_pins = 4'h0;
    wake_event = 1'b0;
    core_irq = 1'b0;
    cfg_req = '0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    idle(8);
    // Reset values and decoded zero fields
    rd_chk(8'h84, 32'h0000_0000);
    rd_chk(8'h88, 32'h0000_0000);
    chk("pm_revision_field", 32'h2, {29'h0, caps.pm_revision_field});
    chk("aux_current", 32'h0, {29'h0, caps.aux_current});
    chk("prog_interface_code", 32'h0, {24'h0, caps.prog_interface_code});
    chk("intr_pin_register", 32'h1, {24'h0, caps.intr_pin_register});
    // All ones: only enable and state stick, fixed bytes stay zero
    cfg_cycle(1'b1, 8'h84, 4'hF, 32'hFFFF_FFFF);
    rd_chk(8'h84, 32'h0000_0103);
    // Every power state code, reported on the port too
    for (int s = 0; s < 4; s++) begin
      cfg_cycle(1'b1, 8'h84, 4'h1, {30'h0, s[1:0]});
      rd_chk(8'h84, 32'h0000_0100 | s);
      chk("power_state_field", s, {30'h0, power_state_field});
    end
    // Wake event with enable set: status and request
    @(posedge ref_clk);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    #1;
    chk("wake_request", 32'h1, {31'h0, wake_request});
    rd_chk(8'h84, 32'h0000_8103);
    cfg_cycle(1'b1, 8'h84, 4'h2, 32'h0000_8100);
    rd_chk(8'h84, 32'h0000_0103);
    chk("wake_request", 32'h0, {31'h0, wake_request});
    // General control: bit 2 never sticks
    cfg_cycle(1'b1, 8'h88, 4'hF, 32'hFFFF_FFFF);
    rd_chk(8'h88, 32'h0000_00FB);
    idle(3);
    chk("pm_revision_field", 32'h3, {29'h0, caps.pm_revision_field});
    chk("cold_wake_capable", 32'h1, {31'h0, caps.cold_wake_capable});
    chk("aux_current", 32'h1, {29'h0, caps.aux_current});
    chk("high_speed_cap", 32'h1, {31'h0, caps.high_speed_cap});
    chk("dma_cap", 32'h1, {31'h0, caps.dma_cap});
    chk("prog_interface_code", 32'h1, {24'h0, caps.prog_interface_code});
    chk("intr_pin_register", 32'h4, {24'h0, caps.intr_pin_register});
    // Interrupt on line D, then override pin B wins
    @(posedge ref_clk);
    core_irq <= 1'b1;
    idle(3);
    chk("intr_req", 32'h8, {28'h0, intr_req});
    @(posedge ref_clk);
    intr_override_pins <= 4'h6;
    idle(10);
    chk("intr_req", 32'h2, {28'h0, intr_req});
    chk("intr_pin_register", 32'h2, {24'h0, caps.intr_pin_register});
    @(posedge ref_clk);
    intr_override_pins <= 4'h0;
    core_irq <= 1'b0;
    // Leave D3hot for D0 with core kept by global reset only
    cfg_cycle(1'b1, 8'h84, 4'h1, 32'h0);
    chk("d3_exit_reset", 32'h1, {31'h0, d3_exit_reset});
    idle(1);
    chk("func_reset", 32'h1, {31'h0, func_reset});
    chk("sd_core_reset", 32'h0, {31'h0, sd_core_reset});
    idle(4);
    rd_chk(8'h84, 32'h0000_0100);
    rd_chk(8'h88, 32'h0000_00F1);
    chk("high_speed_cap", 32'h0, {31'h0, caps.high_speed_cap});
    // Bus reset with scope bit clear resets the core
    pulse_bus_reset(1'b1);
    rd_chk(8'h84, 32'h0000_0100);
    rd_chk(8'h88, 32'h0000_00F1);
    // Scope bit set: bus reset leaves the core alone
    cfg_cycle(1'b1, 8'h88, 4'h1, 32'h0000_00F9);
    pulse_bus_reset(1'b0);
    rd_chk(8'h88, 32'h0000_00F1);
    // Unmapped dword reads zero and ignores writes
    cfg_cycle(1'b1, 8'h8C, 4'hF, 32'hA5A5_A5A5);
    rd_chk(8'h8C, 32'h0000_0000);
    // Global reset clears everything; wake sets status with enable clear
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    idle(8);
    rd_chk(8'h84, 32'h0000_0000);
    rd_chk(8'h88, 32'h0000_0000);
    @(posedge ref_clk);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    #1;
    chk("wake_request", 32'h0, {31'h0, wake_request});
    rd_chk(8'h84, 32'h0000_8000);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
